//--- rtl/rx_mode_pkg.sv
// Constants, register map and mode type for the receiver mode and lock controller
// Behaviour
// - Lock high when locked in active mode
// - All digital outputs low while unlocked (code: only data, pixel clock, select status and ioProcEnable)
// - Auto mode drives both select pins as status
// - Manual mode reads both select pins as inputs
// - Auto ASI status high only on ASI lock
// - Auto video status high only on SMPTE lock
// - Manual ASI select high forces ASI mode
// - Manual ASI select low disables ASI decoding
// - Manual video select alone gives SMPTE mode
// - Manual video select low disables SMPTE processing
// - Manual mode reclocks non-compliant data too
// - Flywheel enable high turns flywheel on in SMPTE mode only
// - Flywheel off disables timing TRS checks
// - FIFO enabled sends data on read strobe
// - FIFO bypassed sends data on pixel clock
// - Pixel clock output follows 27 MHz word rate with FIFO bypassed, held low with FIFO enabled
// - Ten bit output word, bit 9 MSB
package rx_mode_pkg;

    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          WORD_W         = 10;
    localparam int          INT_W          = 3;
    localparam int          CNT_W          = 16;
    localparam int          SYNC_STAGES    = 3;
    localparam int          CTRL_PINS      = 5;

    localparam logic [7:0]  STATUS_OFS     = 8'h00;
    localparam logic [7:0]  INT_STATUS_OFS = 8'h04;
    localparam logic [7:0]  INT_MASK_OFS   = 8'h08;
    localparam logic [7:0]  PINS_OFS       = 8'h0C;
    localparam logic [7:0]  LOSS_CNT_OFS   = 8'h10;

    localparam int          ST_LOCKED      = 0;
    localparam int          ST_MODE_LSB    = 1;
    localparam int          ST_AUTO        = 3;
    localparam int          ST_FIFO        = 4;
    localparam int          ST_FLYWHEEL    = 5;
    localparam int          ST_IOPROC      = 6;

    localparam int          INT_LOCK_GAIN  = 0;
    localparam int          INT_LOCK_LOSS  = 1;
    localparam int          INT_MODE_CHG   = 2;
    localparam logic [2:0]  INT_MASK_RESET = 3'h0;

    localparam int          PIN_AUTO       = 0;
    localparam int          PIN_DVB        = 1;
    localparam int          PIN_VIDEO      = 2;
    localparam int          PIN_FLYWHEEL   = 3;
    localparam int          PIN_FIFO       = 4;

    localparam int          PIXEL_RATE_HZ  = 27000000;
    localparam int          CLOCK_HZ       = 40000000;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_SMPTE,
        MODE_ASI,
        MODE_THROUGH
    } mode_t;

endpackage : rx_mode_pkg

//--- rtl/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
module pin_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] value;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    // Stage one feeds stage two only
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = pinIn;
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        st_nxt.value = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.value);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pinOut = st_r.value;

endmodule : pin_sync

//--- rtl/rx_mode_ctrl.sv
// Mode selection, lock status, output gating and APB register file of the receiver
//
// Local design decisions: register access over APB and the register offsets.
module rx_mode_ctrl (
    input  wire logic        clock,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // Asynchronous control pins
    input  wire logic        autoManualSelect,
    input  wire logic        flywheelEnable,
    input  wire logic        fifoEnable,
    input  wire logic        dvbAsiIn,
    output logic             dvbAsiOut,
    output logic             dvbAsiOe,
    input  wire logic        videoPathSelectIn,
    output logic             videoPathSelectOut,
    output logic             videoPathSelectOe,
    // Lock reports from the receive engines
    input  wire logic        smpteLockIn,
    input  wire logic        asiLockIn,
    input  wire logic        reclockLockIn,
    // Word sources
    input  wire logic        pixelStrobe,
    input  wire logic [9:0]  pixelWord,
    input  wire logic        readStrobe,
    input  wire logic [9:0]  fifoWord,
    // Outputs to the engines and the parallel port
    output logic             locked,
    output logic [9:0]       dataOut,
    output logic             pixelClockOut,
    output logic             asiDecodeEnable,
    output logic             smpteDecodeEnable,
    output logic             ioProcEnable,
    output logic             flywheelOn,
    output logic             timingTrsCheck,
    output logic             fifoActive
);

    typedef struct packed {
        rx_mode_pkg::mode_t  mode;
        logic                locked;
        logic [9:0]          data;
        logic                pclk;
        logic                dvbOut;
        logic                dvbOe;
        logic                vidOut;
        logic                vidOe;
        logic                asiDec;
        logic                smpteDec;
        logic                ioProc;
        logic                flywheel;
        logic                trsCheck;
        logic                fifo;
        logic [2:0]          intStat;
        logic [2:0]          intMask;
        logic [15:0]         lossCnt;
        logic                ready;
        logic                slverr;
        logic [31:0]         rdata;
        logic                irq;
    } state_t;

    state_t     st_r;
    state_t     st_nxt;
    logic [4:0] pinsSync;
    logic       autoSync;
    logic       dvbSync;
    logic       vidSync;
    logic       flySync;
    logic       fifoSync;

    // Every control pin is resynchronised before it may switch the mode
    pin_sync #(
        .WIDTH  (rx_mode_pkg::CTRL_PINS)
    ) u_pin_sync (
        .clock  (clock),
        .reset_n(reset_n),
        .pinIn  ({fifoEnable, flywheelEnable, videoPathSelectIn, dvbAsiIn, autoManualSelect}),
        .pinOut (pinsSync)
    );

    assign autoSync = pinsSync[rx_mode_pkg::PIN_AUTO];
    assign dvbSync  = pinsSync[rx_mode_pkg::PIN_DVB];
    assign vidSync  = pinsSync[rx_mode_pkg::PIN_VIDEO];
    assign flySync  = pinsSync[rx_mode_pkg::PIN_FLYWHEEL];
    assign fifoSync = pinsSync[rx_mode_pkg::PIN_FIFO];

    function automatic logic [31:0] status_word(input state_t s);
        logic [31:0] w;
        w = '0;
        w[rx_mode_pkg::ST_LOCKED]                          = s.locked;
        w[rx_mode_pkg::ST_MODE_LSB+1:rx_mode_pkg::ST_MODE_LSB] = s.mode;
        w[rx_mode_pkg::ST_AUTO]                            = s.dvbOe;
        w[rx_mode_pkg::ST_FIFO]                            = s.fifo;
        w[rx_mode_pkg::ST_FLYWHEEL]                        = s.flywheel;
        w[rx_mode_pkg::ST_IOPROC]                          = s.ioProc;
        return w;
    endfunction : status_word

    logic       access;
    logic       doWrite;
    logic       mapped;
    logic [2:0] events;

    always_comb begin
        st_nxt = st_r;

        // Mode choice
        if (autoSync) begin
            if (asiLockIn) begin
                st_nxt.mode = rx_mode_pkg::MODE_ASI;
            end else if (smpteLockIn) begin
                st_nxt.mode = rx_mode_pkg::MODE_SMPTE;
            end else begin
                st_nxt.mode = rx_mode_pkg::MODE_NONE;
            end
        end else if (dvbSync) begin
            st_nxt.mode = rx_mode_pkg::MODE_ASI;
        end else if (vidSync) begin
            st_nxt.mode = rx_mode_pkg::MODE_SMPTE;
        end else begin
            st_nxt.mode = rx_mode_pkg::MODE_THROUGH;
        end

        unique case (st_nxt.mode)
            rx_mode_pkg::MODE_SMPTE:   st_nxt.locked = smpteLockIn;
            rx_mode_pkg::MODE_ASI:     st_nxt.locked = asiLockIn;
            rx_mode_pkg::MODE_THROUGH: st_nxt.locked = reclockLockIn;
            rx_mode_pkg::MODE_NONE:    st_nxt.locked = 1'b0;
        endcase

        // Decoder enables follow the mode: live while unlocked in manual mode, both low in auto mode until an engine locks
        st_nxt.asiDec   = (st_nxt.mode == rx_mode_pkg::MODE_ASI);
        st_nxt.smpteDec = (st_nxt.mode == rx_mode_pkg::MODE_SMPTE);
        st_nxt.ioProc   = st_nxt.smpteDec && st_nxt.locked;
        st_nxt.flywheel = flySync && st_nxt.smpteDec;
        st_nxt.trsCheck = st_nxt.flywheel;
        st_nxt.fifo     = fifoSync;

        // Select pins: status outputs in auto mode, released in manual mode
        st_nxt.dvbOe  = autoSync;
        st_nxt.vidOe  = autoSync;
        st_nxt.dvbOut = autoSync && st_nxt.locked
                        && (st_nxt.mode == rx_mode_pkg::MODE_ASI);
        st_nxt.vidOut = autoSync && st_nxt.locked
                        && (st_nxt.mode == rx_mode_pkg::MODE_SMPTE);

        // Parallel word path
        if (!st_nxt.locked) begin
            st_nxt.data = '0;
            st_nxt.pclk = 1'b0;
        end else if (fifoSync) begin
            st_nxt.pclk = 1'b0;
            if (readStrobe) begin
                st_nxt.data = fifoWord;
            end
        end else begin
            st_nxt.pclk = pixelStrobe;
            if (pixelStrobe) begin
                st_nxt.data = pixelWord;
            end
        end

        // Lock and mode events
        events = '0;
        events[rx_mode_pkg::INT_LOCK_GAIN] = st_nxt.locked && !st_r.locked;
        events[rx_mode_pkg::INT_LOCK_LOSS] = !st_nxt.locked && st_r.locked;
        events[rx_mode_pkg::INT_MODE_CHG]  = (st_nxt.mode != st_r.mode);
        if (events[rx_mode_pkg::INT_LOCK_LOSS] && (st_r.lossCnt != '1)) begin
            st_nxt.lossCnt = st_r.lossCnt + 16'h0001;
        end

        // APB: one wait state, registered answer
        access  = psel && penable && st_r.ready;
        doWrite = access && pwrite;
        mapped  = (paddr == rx_mode_pkg::STATUS_OFS) || (paddr == rx_mode_pkg::INT_STATUS_OFS)
                  || (paddr == rx_mode_pkg::INT_MASK_OFS) || (paddr == rx_mode_pkg::PINS_OFS)
                  || (paddr == rx_mode_pkg::LOSS_CNT_OFS);

        st_nxt.intStat = st_r.intStat;
        if (doWrite && (paddr == rx_mode_pkg::INT_STATUS_OFS)) begin
            st_nxt.intStat = st_r.intStat & ~pwdata[2:0];
        end
        if (doWrite && (paddr == rx_mode_pkg::INT_MASK_OFS)) begin
            st_nxt.intMask = pwdata[2:0];
        end
        // A new event beats a clear in the same cycle
        st_nxt.intStat = st_nxt.intStat | events;
        st_nxt.irq     = |(st_nxt.intStat & st_nxt.intMask);

        if (psel && penable && !st_r.ready) begin
            st_nxt.ready  = 1'b1;
            st_nxt.slverr = !mapped;
            st_nxt.rdata  = '0;
            if (!pwrite) begin
                unique case (paddr)
                    rx_mode_pkg::STATUS_OFS:     st_nxt.rdata = status_word(st_r);
                    rx_mode_pkg::INT_STATUS_OFS: st_nxt.rdata = {29'h0, st_r.intStat};
                    rx_mode_pkg::INT_MASK_OFS:   st_nxt.rdata = {29'h0, st_r.intMask};
                    rx_mode_pkg::PINS_OFS:       st_nxt.rdata = {27'h0, pinsSync};
                    rx_mode_pkg::LOSS_CNT_OFS:   st_nxt.rdata = {16'h0, st_r.lossCnt};
                    default:                     st_nxt.rdata = '0;
                endcase
            end
        end else begin
            st_nxt.ready  = 1'b0;
            st_nxt.slverr = 1'b0;
            st_nxt.rdata  = '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r         <= '0;
            st_r.intMask <= rx_mode_pkg::INT_MASK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata             = st_r.rdata;
    assign pready             = st_r.ready;
    assign pslverr            = st_r.slverr;
    assign irq                = st_r.irq;
    assign dvbAsiOut          = st_r.dvbOut;
    assign dvbAsiOe           = st_r.dvbOe;
    assign videoPathSelectOut = st_r.vidOut;
    assign videoPathSelectOe  = st_r.vidOe;
    assign locked             = st_r.locked;
    assign dataOut            = st_r.data;
    assign pixelClockOut      = st_r.pclk;
    assign asiDecodeEnable    = st_r.asiDec;
    assign smpteDecodeEnable  = st_r.smpteDec;
    assign ioProcEnable       = st_r.ioProc;
    assign flywheelOn         = st_r.flywheel;
    assign timingTrsCheck     = st_r.trsCheck;
    assign fifoActive         = st_r.fifo;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_lock_source: assert property (
        locked |-> (($past(smpteLockIn) && st_r.mode == rx_mode_pkg::MODE_SMPTE)
                 || ($past(asiLockIn) && st_r.mode == rx_mode_pkg::MODE_ASI)
                 || ($past(reclockLockIn) && st_r.mode == rx_mode_pkg::MODE_THROUGH)))
        else $error("lock high without a matching engine lock");

    a_unlock_quiet: assert property (
        !locked |-> (dataOut == 10'h000 && !pixelClockOut && !dvbAsiOut
                     && !videoPathSelectOut && !ioProcEnable))
        else $error("output active while unlocked");

    a_auto_drive: assert property (
        autoSync |=> (dvbAsiOe && videoPathSelectOe))
        else $error("select pins not driven in auto mode");

    a_manual_release: assert property (
        !autoSync |=> (!dvbAsiOe && !videoPathSelectOe))
        else $error("select pins driven in manual mode");

    a_auto_asi_stat: assert property (
        (autoSync && asiLockIn) |=> dvbAsiOut)
        else $error("ASI status missing on ASI lock");

    a_auto_vid_stat: assert property (
        videoPathSelectOut |-> ($past(smpteLockIn) && !$past(asiLockIn) && ioProcEnable))
        else $error("video status without SMPTE lock");

    a_manual_asi: assert property (
        (!autoSync && dvbSync) |=> (st_r.mode == rx_mode_pkg::MODE_ASI && asiDecodeEnable))
        else $error("manual ASI select not obeyed");

    a_asi_off: assert property (
        (!autoSync && !dvbSync) |=> !asiDecodeEnable)
        else $error("ASI decoding while deselected");

    a_manual_smpte: assert property (
        (!autoSync && !dvbSync && vidSync) |=> smpteDecodeEnable)
        else $error("manual SMPTE select not obeyed");

    a_smpte_off: assert property (
        (!autoSync && !vidSync) |=> (!smpteDecodeEnable && !ioProcEnable))
        else $error("SMPTE processing while deselected");

    a_data_through: assert property (
        (!autoSync && !dvbSync && !vidSync && reclockLockIn) |=> locked)
        else $error("data-through lock not reported");

    a_flywheel_off: assert property (
        !flySync |=> (!flywheelOn && !timingTrsCheck))
        else $error("flywheel active while disabled");

    a_fifo_word: assert property (
        (fifoSync && readStrobe) |=> (!locked || dataOut == $past(fifoWord)))
        else $error("FIFO word not presented on read strobe");

    a_bypass_word: assert property (
        (!fifoSync && pixelStrobe) |=> (!locked || (dataOut == $past(pixelWord) && pixelClockOut)))
        else $error("pixel word not presented in bypass");

    a_irq_level: assert property (
        ##1 (irq == $past(|(st_nxt.intStat & st_nxt.intMask))))
        else $error("interrupt level does not follow status and mask");

    a_flywheel_on: assert property (
        (flySync && !autoSync && !dvbSync && vidSync) |=> (flywheelOn && timingTrsCheck))
        else $error("flywheel not enabled in SMPTE mode");

    a_fifo_no_pclk: assert property (
        fifoSync |=> !pixelClockOut)
        else $error("pixel clock pulses while the FIFO is enabled");

    a_pclk_idle: assert property (
        (!fifoSync && !pixelStrobe) |=> !pixelClockOut)
        else $error("pixel clock pulse without a recovered word");

    a_gain_sticky: assert property (
        $rose(locked) |-> st_r.intStat[rx_mode_pkg::INT_LOCK_GAIN])
        else $error("lock gain not recorded");

    a_loss_sticky: assert property (
        $fell(locked) |-> st_r.intStat[rx_mode_pkg::INT_LOCK_LOSS])
        else $error("lock loss not recorded");

    a_loss_count: assert property (
        ($fell(locked) && $past(st_r.lossCnt) != 16'hFFFF)
        |-> (st_r.lossCnt == $past(st_r.lossCnt) + 16'h0001))
        else $error("lock loss count not advanced");

    a_one_wait: assert property (
        (psel && penable && !pready) |=> pready)
        else $error("access not answered after one wait state");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    a_error_data: assert property (
        pslverr |-> (pready && prdata == 32'h0000_0000))
        else $error("error response without ready or with data");

endmodule : rx_mode_ctrl

//--- sim/app_side_model.sv
// Application-side model: select pins and FIFO read strobe
module app_side_model (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       wantDvb,
    input  wire logic       wantVideo,
    input  wire logic       fifoOn,
    input  wire logic       dvbAsiOut,
    input  wire logic       dvbAsiOe,
    input  wire logic       videoPathSelectOut,
    input  wire logic       videoPathSelectOe,
    output logic            dvbAsiIn,
    output logic            videoPathSelectIn,
    output logic            readStrobe,
    output logic [9:0]      fifoWord
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // The device owns the pin while enabled, the application otherwise
    assign dvbAsiIn          = dvbAsiOe ? dvbAsiOut : wantDvb;
    assign videoPathSelectIn = videoPathSelectOe ? videoPathSelectOut : wantVideo;
    // Read clock at a third of the system rate; the word changes every cycle
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase      <= 2'h0;
            readStrobe <= 1'b0;
            fifoWord   <= 10'h000;
        end else begin
            phase      <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            readStrobe <= fifoOn && (phase == 2'h2);
            fifoWord   <= 10'($urandom);
        end
    end
endmodule : app_side_model

//--- sim/test_rx_mode_select_and_lock_status.sv
// Self-checking bench for the receiver mode and lock controller
module test_rx_mode_select_and_lock_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        autoSel, flyPin, fifoPin, wantDvb, wantVideo;
    logic        dvbIn, dvbOut, dvbOe, vidIn, vidOut, vidOe;
    logic        smpteLock, asiLock, reclkLock, pixelStrobe, readStrobe;
    logic [9:0]  pixelWord, fifoWord, dataOut, expW;
    logic        locked, pixClk, asiDec, smpDec, ioProc, flyOn, trsChk, fifoAct;
    logic        prevL, prevF, chkOn, strobeSeen;
    logic [11:0] lv;
    logic [32:0] rdQ[$];
    int          nErrors, samplesChecked, cycles;

    assign lv = {locked, dvbOut, dvbOe, vidOut, vidOe, asiDec, smpDec, ioProc,
                 flyOn, trsChk, fifoAct, irq};

    rx_mode_ctrl i_rx_mode_ctrl (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .autoManualSelect(autoSel), .flywheelEnable(flyPin), .fifoEnable(fifoPin),
        .dvbAsiIn(dvbIn), .dvbAsiOut(dvbOut), .dvbAsiOe(dvbOe),
        .videoPathSelectIn(vidIn), .videoPathSelectOut(vidOut),
        .videoPathSelectOe(vidOe), .smpteLockIn(smpteLock), .asiLockIn(asiLock),
        .reclockLockIn(reclkLock), .pixelStrobe(pixelStrobe), .pixelWord(pixelWord),
        .readStrobe(readStrobe), .fifoWord(fifoWord), .locked(locked),
        .dataOut(dataOut), .pixelClockOut(pixClk), .asiDecodeEnable(asiDec),
        .smpteDecodeEnable(smpDec), .ioProcEnable(ioProc), .flywheelOn(flyOn),
        .timingTrsCheck(trsChk), .fifoActive(fifoAct)
    );

    app_side_model i_app_side_model (
        .clock(clock), .reset_n(reset_n), .wantDvb(wantDvb), .wantVideo(wantVideo),
        .fifoOn(fifoPin), .dvbAsiOut(dvbOut), .dvbAsiOe(dvbOe),
        .videoPathSelectOut(vidOut), .videoPathSelectOe(vidOe), .dvbAsiIn(dvbIn),
        .videoPathSelectIn(vidIn), .readStrobe(readStrobe), .fifoWord(fifoWord)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rdQ.push_back(exp);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic lvl(input int n, input logic [11:0] m, input logic [11:0] e);
        repeat (n) @(posedge clock);
        chk(33'(lv & m), 33'(e));
    endtask : lvl

    // Read results are compared against the oldest pending expectation
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && rdQ.size() > 0)
            chk({pslverr, prdata}, rdQ.pop_front());
    end

    // Recovered word source at the pixel rate
    always @(posedge clock) begin
        pixelStrobe <= ($urandom_range(39) < 27);
        pixelWord   <= 10'($urandom);
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            nErrors++;
            end_of_test();
        end
        prevL      <= locked;
        prevF      <= fifoAct;
        chkOn      <= locked && prevL && (fifoAct == prevF) && (fifoAct == fifoPin);
        strobeSeen <= fifoAct ? readStrobe : pixelStrobe;
        expW       <= fifoAct ? fifoWord : pixelWord;
    end

    always @(negedge clock) begin
        if (chkOn && locked && strobeSeen) chk(33'(dataOut), 33'(expW));
        if (chkOn && locked && !prevF) chk(33'(pixClk), 33'(strobeSeen));
        if (!locked && !prevL) chk(33'({pixClk, dataOut}), 33'h0);
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {autoSel, flyPin, fifoPin, wantDvb, wantVideo} = '0;
        {smpteLock, asiLock, reclkLock} = '0;
        void'($urandom(96144));
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        autoSel <= 1'b1;
        flyPin  <= 1'b1;
        repeat (10) @(posedge clock);
        rd(rx_mode_pkg::PINS_OFS, 33'h0_0000_0009);
        rd(rx_mode_pkg::INT_MASK_OFS, 33'h0);
        apb(1'b1, rx_mode_pkg::INT_STATUS_OFS, 32'h0000_0007);
        apb(1'b1, rx_mode_pkg::INT_MASK_OFS, 32'h0000_0001);
        asiLock <= 1'b1;
        lvl(3, 12'hFD3, 12'hEC1);
        rd(rx_mode_pkg::INT_STATUS_OFS, 33'h0_0000_0005);
        apb(1'b1, rx_mode_pkg::INT_STATUS_OFS, 32'h0000_0001);
        lvl(2, 12'h001, 12'h000);
        asiLock   <= 1'b0;
        smpteLock <= 1'b1;
        lvl(3, 12'hFFF, 12'hBBC);
        flyPin <= 1'b0;
        lvl(8, 12'h00C, 12'h000);
        smpteLock <= 1'b0;
        lvl(3, 12'hD11, 12'h000);
        rd(rx_mode_pkg::INT_STATUS_OFS, 33'h0_0000_0006);
        rd(rx_mode_pkg::LOSS_CNT_OFS, 33'h0_0000_0001);
        rd(8'h14, 33'h1_0000_0000);
        autoSel   <= 1'b0;
        wantDvb   <= 1'b1;
        wantVideo <= 1'b1;
        flyPin    <= 1'b1;
        repeat (8) @(posedge clock);
        asiLock   <= 1'b1;
        smpteLock <= 1'b1;
        lvl(3, 12'hAE0, 12'h840);
        wantDvb <= 1'b0;
        lvl(8, 12'h878, 12'h838);
        wantVideo <= 1'b0;
        flyPin    <= 1'b0;
        reclkLock <= 1'b1;
        lvl(8, 12'h870, 12'h800);
        rd(rx_mode_pkg::STATUS_OFS, 33'h0_0000_0007);
        fifoPin <= 1'b1;
        lvl(8, 12'h002, 12'h002);
        repeat (40) @(posedge clock);
        {asiLock, smpteLock, reclkLock} <= 3'h0;
        lvl(20, 12'h800, 12'h000);
        end_of_test();
    end
endmodule : test_rx_mode_select_and_lock_status
